/* shared/vrs_params.svh */
`ifndef VRS_PARAMS_SVH
`define VRS_PARAMS_SVH
// clock and timed delays
`define VRS_CLK_NS        20
`define VRS_MASK_NS       50000
`define VRS_CPU_CLOCK_ENABLE_OUT_NS      60000
`define VRS_PGOOD_NS      5000000
`define VRS_MASK_CYC      ((`VRS_MASK_NS + `VRS_CLK_NS - 1) / `VRS_CLK_NS)
`define VRS_CPU_CLOCK_ENABLE_OUT_CYC     ((`VRS_CPU_CLOCK_ENABLE_OUT_NS + `VRS_CLK_NS - 1) / `VRS_CLK_NS)
`define VRS_PGOOD_CYC     ((`VRS_PGOOD_NS + `VRS_CLK_NS - 1) / `VRS_CLK_NS)
// soft ramps run at one eighth of the programmed rate
`define VRS_SOFT_SHIFT    3
`define VRS_BLANK_CYCLES  6'h20
// register byte offsets
`define VRS_REG_SLEW      8'h00
`define VRS_REG_BOOT      8'h04
`define VRS_REG_STATUS    8'h08
// reset values
`define VRS_SLEW_RESET    16'h0028
`define VRS_BOOT_RESET    7'h30
// status field positions
`define VRS_STAT_TARGET   0
`define VRS_STAT_STATE    8
`define VRS_STAT_FAULT    12
`define VRS_STAT_HOT      13
`define VRS_STAT_PGOOD    14
`define VRS_STAT_CPU_CLOCK_ENABLE_OUT    15
// bus responses
`define VRS_RESP_OKAY     2'h0
`define VRS_RESP_SLVERR   2'h2
`endif

/* shared/vrs_pkg.sv */
package vrs_pkg;
	// sequencer states
	typedef enum logic [2:0] {
		VRS_OFF,
		VRS_REF_WAIT,
		VRS_MASK,
		VRS_SOFT_START,
		VRS_BOOT_HOLD,
		VRS_RUN,
		VRS_SOFT_STOP,
		VRS_FAULT_PARK
	} vrs_state_type;
endpackage : vrs_pkg

/* verilog/vrs_ramp.sv */
`timescale 1ns/1ps
module vrs_ramp #(
	parameter int CW = 7,
	parameter int PW = 19
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          clear,
	input  wire logic [CW-1:0] goal,
	input  wire logic [PW-1:0] period,
	output logic      [CW-1:0] target,
	output logic               moving
);
	import vrs_pkg::*;

	logic [PW-1:0] step_cnt;

	// one code step per period cycles; a zero period behaves as one
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			target   <= '0;
			step_cnt <= '0;
		end else if (target != goal) begin
			if (step_cnt + PW'(1) >= period) begin
				step_cnt <= '0;
				target   <= (target < goal) ? target + CW'(1) : target - CW'(1);
			end else begin
				step_cnt <= step_cnt + PW'(1);
			end
		end else begin
			step_cnt <= '0;
		end
	end

	assign moving = (target != goal);
endmodule : vrs_ramp

/* verilog/vrs_sequencer.sv */
`timescale 1ns/1ps
`include "vrs_params.svh"
// How it works
// - enable waits for reference ready, then a 50us mask before switching
// - supply above power-on level clears fault latch and readies the controller
// - no switching while supply lockout is asserted
// - soft-start ramps target to boot code at one eighth slew rate
// - clock enable driven low 60us after boot if upstream good; slew to code
// - power-good and phase-good released 5ms after clock enable goes low
// - soft ramps use forced PWM, ignoring deep-sleep and phase select
// - fault latch keeps device off until enable toggled or supply below 0.5V
// - supply lockout in operation shuts down at once, outputs high impedance
// - enable low pulls power-good low and ramps to zero at eighth rate
// - normal ramp to zero disables drivers, low sides low, lowest power
// - undervoltage or thermal fault starts shutdown and sets the fault latch
// - undervoltage fault when output sits 400mV below target
// - after fault ramp: low sides high, high sides low
// - thermal trip latches fault; clearing by enable waits for 15C cooling
// - test level on enable disables protection and clears the fault latch
// - phase-good high impedance in single-phase operation
// - phase-good blanked for 32 second-phase high-side cycles on return
// - phase-good high impedance while slewing, driven low when shut down
// - a switch turns on only when its opposite drive is off
// - phase select low disables phase two at once, both drives low
module vrs_sequencer #(
	parameter int PGOOD_CYC = `VRS_PGOOD_CYC,
	parameter int ADDR_W    = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              enable_bar_input,
	input  wire logic              test_level_detect,
	input  wire logic              supply_por_ok,
	input  wire logic              supply_undervolt_lockout,
	input  wire logic              supply_below_half,
	input  wire logic              reference_ready,
	input  wire logic              output_undervolt_protect,
	input  wire logic              overtemp_trip,
	input  wire logic              overtemp_cooled,
	input  wire logic              upstream_good_input,
	input  wire logic              deep_sleep_request,
	input  wire logic              low_power_phase_select,
	input  wire logic              phase_imbalance,
	input  wire logic              zero_cross_one,
	input  wire logic              zero_cross_two,
	input  wire logic              pwm_one_req,
	input  wire logic              pwm_two_req,
	input  wire logic              high_side_off_one,
	input  wire logic              high_side_off_two,
	input  wire logic              low_side_off_one,
	input  wire logic              low_side_off_two,
	input  wire logic [6:0]        voltage_code_inputs,
	output logic                   high_side_drive_one,
	output logic                   high_side_drive_two,
	output logic                   low_side_drive_one,
	output logic                   low_side_drive_two,
	output logic                   output_in_regulation_flag_o,
	output logic                   output_in_regulation_flag_oe,
	output logic                   phase_balance_ok_o,
	output logic                   phase_balance_ok_oe,
	output logic                   cpu_clock_enable_out,
	output logic                   switcher_hiz,
	output logic                   low_power_state,
	output logic                   forced_pwm_mode,
	output logic [6:0]             target_code,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp
);
	import vrs_pkg::*;

	localparam int TW = 18;
	localparam int PW = 19;

	vrs_state_type state;
	vrs_state_type next_state;
	logic [27:0]   sync1;
	logic [27:0]   sync2;
	logic          en_s, test_s, por_s, supply_undervolt_lockout_s, half_s, ref_s, uvp_s, hot_s, cool_s;
	logic          upg_s, deep_s, psi_s, imb_s, zc1_s, zc2_s, pwm1_s, pwm2_s;
	logic          hsoff1_s, hsoff2_s, lsoff1_s, lsoff2_s;
	logic [6:0]    vid_s;
	logic [6:0]    vid_prev, vid_q;
	logic [TW-1:0] timer;
	logic          fault_latch, hot_hold, pg_released;
	logic [15:0]   slew_period;
	logic [6:0]    boot_code;
	logic [6:0]    goal;
	logic [PW-1:0] period;
	logic [6:0]    target;
	logic          moving;
	logic          active, soft_ramp, single_eff, want_fpwm, phase2_on, park;
	logic          fault_trip, stop_req;
	logic [5:0]    blank_cnt;
	logic          aw_held, w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          wr_fire;

	// pins come from the analog side: two flops before any use
	always_ff @(posedge aclk) begin
		sync1 <= {enable_bar_input, test_level_detect, supply_por_ok, supply_undervolt_lockout,
			supply_below_half, reference_ready, output_undervolt_protect, overtemp_trip,
			overtemp_cooled, upstream_good_input, deep_sleep_request, low_power_phase_select,
			phase_imbalance, zero_cross_one, zero_cross_two, pwm_one_req, pwm_two_req,
			high_side_off_one, high_side_off_two, low_side_off_one, low_side_off_two,
			voltage_code_inputs};
		sync2 <= sync1;
	end

	assign {en_s, test_s, por_s, supply_undervolt_lockout_s, half_s, ref_s, uvp_s, hot_s, cool_s, upg_s, deep_s,
		psi_s, imb_s, zc1_s, zc2_s, pwm1_s, pwm2_s, hsoff1_s, hsoff2_s, lsoff1_s, lsoff2_s,
		vid_s} = sync2;

	// code word taken only when two synced samples agree, so skewed bits never reach the ramp
	always_ff @(posedge aclk) begin
		vid_prev <= vid_s;
		if (!aresetn) begin
			vid_q <= 7'h00;
		end else if (vid_s == vid_prev) begin
			vid_q <= vid_s;
		end
	end

	// operating mode decode
	assign soft_ramp  = (state == VRS_SOFT_START) || (state == VRS_BOOT_HOLD) ||
		(state == VRS_SOFT_STOP);
	assign active     = !supply_undervolt_lockout_s && por_s && (soft_ramp || state == VRS_RUN);
	assign single_eff = (state == VRS_RUN) && (deep_s || !psi_s);
	assign want_fpwm  = !(state == VRS_RUN && deep_s);
	assign phase2_on  = active && !single_eff;
	assign park       = (state == VRS_FAULT_PARK) && !supply_undervolt_lockout_s;
	// the undervoltage comparator already measures against the live target
	assign fault_trip = !test_s && (uvp_s || hot_s) &&
		(state == VRS_SOFT_START || state == VRS_BOOT_HOLD || state == VRS_RUN);
	assign stop_req   = !en_s || fault_trip || fault_latch;

	// sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			VRS_OFF:        if (en_s && !fault_latch) next_state = VRS_REF_WAIT;
			VRS_REF_WAIT:   if (!en_s) next_state = VRS_OFF;
				else if (ref_s) next_state = VRS_MASK;
			VRS_MASK:       if (!en_s) next_state = VRS_OFF;
				else if (timer == '0) next_state = VRS_SOFT_START;
			VRS_SOFT_START: if (stop_req) next_state = VRS_SOFT_STOP;
				else if (target == boot_code) next_state = VRS_BOOT_HOLD;
			VRS_BOOT_HOLD:  if (stop_req) next_state = VRS_SOFT_STOP;
				else if (timer == '0 && upg_s) next_state = VRS_RUN;
			VRS_RUN:        if (stop_req) next_state = VRS_SOFT_STOP;
			VRS_SOFT_STOP:  if (target == 7'h00)
				next_state = fault_latch ? VRS_FAULT_PARK : VRS_OFF;
			VRS_FAULT_PARK: if (!fault_latch) next_state = VRS_OFF;
		endcase
		if (!por_s || supply_undervolt_lockout_s) begin
			next_state = VRS_OFF;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= VRS_OFF;
		end else begin
			state <= next_state;
		end
	end

	// one delay counter, reloaded on each state entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer <= '0;
		end else if (next_state != state) begin
			unique case (next_state)
				VRS_MASK:      timer <= TW'(`VRS_MASK_CYC - 1);
				VRS_BOOT_HOLD: timer <= TW'(`VRS_CPU_CLOCK_ENABLE_OUT_CYC - 1);
				VRS_RUN:       timer <= TW'(PGOOD_CYC - 1);
				default:       timer <= '0;
			endcase
		end else if (timer != '0) begin
			timer <= timer - TW'(1);
		end
	end

	// fault latch: a trip in the enable-low clearing cycle still sets it; supply and test-level clears win over a trip
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_s || half_s || test_s) begin
			fault_latch <= 1'b0;
		end else if (fault_trip) begin
			fault_latch <= 1'b1;
		end else if (!en_s && !hot_hold) begin
			fault_latch <= 1'b0;
		end
	end

	// a thermal trip blocks the enable-low clear until the die has cooled
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_s) begin
			hot_hold <= 1'b0;
		end else if (fault_trip && hot_s) begin
			hot_hold <= 1'b1;
		end else if (cool_s) begin
			hot_hold <= 1'b0;
		end
	end

	// ramp goal and rate; soft ramps run eight times slower
	always_comb begin
		goal   = 7'h00;
		period = {3'h0, slew_period};
		if (state == VRS_SOFT_START || state == VRS_BOOT_HOLD) begin
			goal = boot_code;
		end else if (state == VRS_RUN) begin
			goal = vid_q;
		end
		if (soft_ramp) begin
			period = {3'h0, slew_period} << `VRS_SOFT_SHIFT;
		end
	end

	vrs_ramp #(.CW(7), .PW(PW)) u_ramp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (state == VRS_OFF || state == VRS_FAULT_PARK),
		.goal    (goal),
		.period  (period),
		.target  (target),
		.moving  (moving)
	);

	// status release 5ms after the clock enable is driven low
	always_ff @(posedge aclk) begin
		if (!aresetn || state != VRS_RUN) begin
			pg_released <= 1'b0;
		end else if (timer == '0) begin
			pg_released <= 1'b1;
		end
	end

	// phase-good blanking counts second-phase high-side turn-ons
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blank_cnt <= '0;
		end else if (single_eff) begin
			blank_cnt <= `VRS_BLANK_CYCLES;
		end else if (blank_cnt != '0 && phase2_on && pwm2_s && !high_side_drive_two &&
			lsoff2_s && !low_side_drive_two) begin
			blank_cnt <= blank_cnt - 6'h01;
		end
	end

	// gate drives: a side turns on only once the opposite drive is sensed off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_side_drive_one <= 1'b0;
			low_side_drive_one  <= 1'b0;
			high_side_drive_two <= 1'b0;
			low_side_drive_two  <= 1'b0;
		end else begin
			high_side_drive_one <= active && pwm1_s && lsoff1_s && !low_side_drive_one;
			low_side_drive_one  <= (park || (active && !pwm1_s && (want_fpwm || !zc1_s))) &&
				hsoff1_s && !high_side_drive_one;
			high_side_drive_two <= phase2_on && pwm2_s && lsoff2_s && !low_side_drive_two;
			low_side_drive_two  <= (park || (phase2_on && !pwm2_s && (want_fpwm || !zc2_s))) &&
				hsoff2_s && !high_side_drive_two;
		end
	end

	// open-drain status pins and plain status outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_in_regulation_flag_o  <= 1'b0;
			output_in_regulation_flag_oe <= 1'b1;
			phase_balance_ok_o           <= 1'b0;
			phase_balance_ok_oe          <= 1'b1;
			cpu_clock_enable_out         <= 1'b1;
			switcher_hiz                 <= 1'b1;
			low_power_state              <= 1'b1;
			forced_pwm_mode              <= 1'b1;
			target_code                  <= 7'h00;
		end else begin
			output_in_regulation_flag_oe <= !supply_undervolt_lockout_s && por_s &&
				!(state == VRS_RUN && pg_released && en_s);
			if (supply_undervolt_lockout_s || !por_s) begin
				phase_balance_ok_oe <= 1'b0;
			end else if (!(state == VRS_SOFT_START || state == VRS_BOOT_HOLD ||
				state == VRS_RUN)) begin
				phase_balance_ok_oe <= 1'b1;
			end else begin
				phase_balance_ok_oe <= !moving && !single_eff && blank_cnt == '0 &&
					(!pg_released || imb_s);
			end
			cpu_clock_enable_out <= !(state == VRS_RUN);
			switcher_hiz         <= supply_undervolt_lockout_s || !por_s;
			low_power_state      <= (state == VRS_OFF);
			forced_pwm_mode      <= want_fpwm;
			target_code          <= target;
		end
	end

	// bus slave: address and data taken in either order, answer one cycle later
	assign wr_fire = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `VRS_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
				awready   <= 1'b0;
			end else if (!aw_held && !bvalid) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				wready   <= 1'b0;
			end else if (!w_held && !bvalid) begin
				wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr_q == ADDR_W'(`VRS_REG_SLEW) ||
					aw_addr_q == ADDR_W'(`VRS_REG_BOOT)) ? `VRS_RESP_OKAY : `VRS_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// software settings: slew step period and boot code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slew_period <= `VRS_SLEW_RESET;
			boot_code   <= `VRS_BOOT_RESET;
		end else if (wr_fire) begin
			if (aw_addr_q == ADDR_W'(`VRS_REG_SLEW)) begin
				if (w_strb_q[0]) slew_period[7:0]  <= w_data_q[7:0];
				if (w_strb_q[1]) slew_period[15:8] <= w_data_q[15:8];
			end
			if (aw_addr_q == ADDR_W'(`VRS_REG_BOOT) && w_strb_q[0]) begin
				boot_code <= w_data_q[6:0];
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `VRS_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `VRS_RESP_OKAY;
			rdata   <= 32'h0000_0000;
			if (araddr == ADDR_W'(`VRS_REG_SLEW)) begin
				rdata[15:0] <= slew_period;
			end else if (araddr == ADDR_W'(`VRS_REG_BOOT)) begin
				rdata[6:0] <= boot_code;
			end else if (araddr == ADDR_W'(`VRS_REG_STATUS)) begin
				rdata[`VRS_STAT_TARGET +: 7] <= target;
				rdata[`VRS_STAT_STATE +: 3]  <= 3'(state);
				rdata[`VRS_STAT_FAULT]       <= fault_latch;
				rdata[`VRS_STAT_HOT]         <= hot_hold;
				rdata[`VRS_STAT_PGOOD]       <= pg_released;
				rdata[`VRS_STAT_CPU_CLOCK_ENABLE_OUT]       <= cpu_clock_enable_out;
			end else begin
				rresp <= `VRS_RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	dead_time_a: assert property (
		!(high_side_drive_one && low_side_drive_one) &&
		!(high_side_drive_two && low_side_drive_two))
		else $error("high and low side driven together");
	lockout_hiz_a: assert property (
		supply_undervolt_lockout_s |=> switcher_hiz && !output_in_regulation_flag_oe && !phase_balance_ok_oe
		##1 !high_side_drive_one && !high_side_drive_two)
		else $error("lockout did not release outputs");
	fault_park_a: assert property (
		state == VRS_FAULT_PARK && $past(state) == VRS_FAULT_PARK
		|-> !high_side_drive_one && !high_side_drive_two)
		else $error("high side on while parked after fault");
	phase_two_a: assert property (
		state == VRS_RUN && !deep_s && !psi_s
		|=> !high_side_drive_two && !low_side_drive_two)
		else $error("phase two drive while phase select low");
	enable_pgood_a: assert property (
		!en_s && !supply_undervolt_lockout_s && por_s |=> output_in_regulation_flag_oe)
		else $error("power-good not pulled low on disable");
	fault_hold_a: assert property (
		fault_latch && en_s && !test_s && !half_s && por_s |=> fault_latch)
		else $error("fault latch dropped without a clearing action");
	test_clear_a: assert property (test_s |=> !fault_latch)
		else $error("test level did not clear fault latch");
	cpu_clock_enable_out_run_a: assert property (state == VRS_RUN |=> !cpu_clock_enable_out)
		else $error("clock enable not low in run");
	single_blank_a: assert property (single_eff |=> !phase_balance_ok_oe)
		else $error("phase-good driven in single phase");
	soft_pwm_a: assert property (soft_ramp |=> forced_pwm_mode)
		else $error("soft ramp left forced pwm");
	por_clear_a: assert property (!por_s |=> !fault_latch && state == VRS_OFF)
		else $error("power-on reset did not clear");
endmodule : vrs_sequencer

/* bench/vrs_partner.sv */
`timescale 1ns/1ps
// processor and platform logic on the far side of the sequencer
module vrs_partner #(
	parameter int GOOD_DELAY = 40
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       sleep_cmd,
	input  wire logic       single_cmd,
	input  wire logic [6:0] code_cmd,
	output logic            upstream_good_input,
	output logic            deep_sleep_request,
	output logic            low_power_phase_select,
	output logic [6:0]      voltage_code_inputs
);
	logic [15:0] wait_cnt;
	// upstream rail reports good only after its own delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_cnt <= 16'h0000;
			upstream_good_input <= 1'b0;
		end else if (wait_cnt < 16'(GOOD_DELAY)) begin
			wait_cnt <= wait_cnt + 16'h0001;
		end else begin
			upstream_good_input <= 1'b1;
		end
	end
	// requests follow the commands one cycle late, like a processor pin
	always_ff @(posedge aclk) begin
		deep_sleep_request <= sleep_cmd & upstream_good_input;
		low_power_phase_select <= !single_cmd;
		voltage_code_inputs <= code_cmd;
	end
endmodule : vrs_partner

/* bench/vrs_sequencer_test.sv */
`timescale 1ns/1ps
module vrs_sequencer_test;
	import vrs_pkg::*;
	localparam int PG = 50;
	logic        aclk, aresetn, enable_bar_input, test_level_detect, supply_por_ok;
	logic        supply_undervolt_lockout, supply_below_half, reference_ready;
	logic        output_undervolt_protect, overtemp_trip, overtemp_cooled, phase_imbalance;
	logic        zero_cross_one, zero_cross_two, pwm_one_req, pwm_two_req, high_side_off_one;
	logic        high_side_off_two, low_side_off_one, low_side_off_two, upstream_good_input;
	logic        deep_sleep_request, low_power_phase_select, sleep_cmd, single_cmd;
	logic        high_side_drive_one, high_side_drive_two, low_side_drive_one, low_side_drive_two;
	logic        output_in_regulation_flag_o, output_in_regulation_flag_oe, phase_balance_ok_o;
	logic        phase_balance_ok_oe, cpu_clock_enable_out, switcher_hiz, low_power_state;
	logic        forced_pwm_mode, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, resp;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	logic [6:0]  voltage_code_inputs, code_cmd, target_code;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, seed;
	int          failures, checks_done, cycles, n;

	vrs_sequencer #(.PGOOD_CYC(PG)) i_vrs_sequencer (.aclk, .aresetn, .enable_bar_input,
		.test_level_detect, .supply_por_ok, .supply_undervolt_lockout, .supply_below_half,
		.reference_ready, .output_undervolt_protect, .overtemp_trip, .overtemp_cooled,
		.upstream_good_input, .deep_sleep_request, .low_power_phase_select, .phase_imbalance,
		.zero_cross_one, .zero_cross_two, .pwm_one_req, .pwm_two_req, .high_side_off_one,
		.high_side_off_two, .low_side_off_one, .low_side_off_two, .voltage_code_inputs,
		.high_side_drive_one, .high_side_drive_two, .low_side_drive_one, .low_side_drive_two,
		.output_in_regulation_flag_o, .output_in_regulation_flag_oe, .phase_balance_ok_o,
		.phase_balance_ok_oe, .cpu_clock_enable_out, .switcher_hiz, .low_power_state,
		.forced_pwm_mode, .target_code, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
		.rvalid, .rready, .rdata, .rresp);
	vrs_partner i_vrs_partner (.aclk, .aresetn, .sleep_cmd, .single_cmd, .code_cmd,
		.upstream_good_input, .deep_sleep_request, .low_power_phase_select,
		.voltage_code_inputs);

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// soft ramps step one code every eight periods
	function automatic int ramp_cycles(input int codes, input int period);
		return codes * 8 * period;
	endfunction : ramp_cycles
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awprot <= seed[2:0];
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arprot <= seed[5:3];
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rdreg
	task automatic go_parked();
		while (target_code !== 7'h00) @(posedge aclk);
		repeat (10) @(posedge aclk);
		chk({high_side_drive_one, high_side_drive_two, low_side_drive_one, low_side_drive_two},
			4'b0011);
	endtask : go_parked

	initial aclk = 1'b0;
	always #10 aclk = ~aclk;
	// modulator noise plus gate sense that reports off one cycle after a drive drops
	always @(posedge aclk) begin
		seed <= xs(seed);
		{pwm_one_req, pwm_two_req, phase_imbalance, zero_cross_one, zero_cross_two} <= seed[4:0];
		high_side_off_one <= !high_side_drive_one;
		high_side_off_two <= !high_side_drive_two;
		low_side_off_one <= !low_side_drive_one;
		low_side_off_two <= !low_side_drive_two;
		cycles <= cycles + 1;
		if (cycles == 70000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		{aresetn, enable_bar_input, test_level_detect, supply_undervolt_lockout} = 4'h0;
		{supply_below_half, reference_ready, output_undervolt_protect, overtemp_trip} = 4'h0;
		{supply_por_ok, overtemp_cooled, sleep_cmd, single_cmd, code_cmd} = 11'h700;
		{pwm_one_req, pwm_two_req, phase_imbalance, zero_cross_one, zero_cross_two} = 5'h00;
		{high_side_off_one, high_side_off_two, low_side_off_one, low_side_off_two} = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 53'h0;
		{awprot, arprot, wstrb} = 10'h00F;
		{seed, failures, checks_done, cycles} = {32'hC2B9, 96'h0};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdreg(8'h00);
		chk(rd, 32'h0000_0028);
		rdreg(8'h04);
		chk(rd, 32'h0000_0030);
		rdreg(8'h0C);
		chk(rd, 32'h0);
		chk(resp, 2'h2);
		wr(8'h0C, seed, 2'h2);
		wr(8'h08, 32'h0, 2'h2);
		wr(8'h00, 32'h1, 2'h0);
		// supply lockout with enable and reference present
		supply_undervolt_lockout <= 1'b1;
		enable_bar_input <= 1'b1;
		reference_ready <= 1'b1;
		repeat (3000) @(posedge aclk);
		chk({switcher_hiz, target_code}, {1'b1, 7'h00});
		supply_undervolt_lockout <= 1'b0;
		enable_bar_input <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			repeat (20) @(posedge aclk);
			reference_ready <= 1'b0;
			enable_bar_input <= 1'b1;
			sleep_cmd <= 1'b1;
			repeat (20) @(posedge aclk);
			chk(target_code, 7'h00);
			reference_ready <= 1'b1;
			for (n = 0; target_code === 7'h00; n++) @(posedge aclk);
			chk(n >= 2500 && n <= 2520, 1'b1);
			for (n = 0; target_code !== 7'h30; n++) @(posedge aclk);
			chk(n >= ramp_cycles(47, 1) && n <= ramp_cycles(47, 1) + 2, 1'b1);
			chk(forced_pwm_mode, 1'b1);
			for (n = 0; cpu_clock_enable_out !== 1'b0; n++) @(posedge aclk);
			chk(n >= 3000 && n <= 3004, 1'b1);
			chk(output_in_regulation_flag_oe, 1'b1);
			code_cmd <= 7'h31 + {1'b0, seed[5:0]};
			repeat (300) @(posedge aclk);
			chk(target_code, code_cmd);
			chk({forced_pwm_mode, phase_balance_ok_oe, high_side_drive_two}, 3'b000);
			sleep_cmd <= 1'b0;
			single_cmd <= 1'b1;
			repeat (8) @(posedge aclk);
			chk({phase_balance_ok_oe, high_side_drive_two, low_side_drive_two}, 3'b000);
			single_cmd <= 1'b0;
			repeat (8) @(posedge aclk);
			chk(phase_balance_ok_oe, 1'b0);
			repeat (PG + 100) @(posedge aclk);
			chk(output_in_regulation_flag_oe, 1'b0);
			if (k == 0) begin
				enable_bar_input <= 1'b0;
				repeat (5) @(posedge aclk);
				chk(output_in_regulation_flag_oe, 1'b1);
				while (low_power_state !== 1'b1) @(posedge aclk);
				chk({high_side_drive_one, low_side_drive_one, phase_balance_ok_oe}, 3'b001);
				chk({output_in_regulation_flag_o, phase_balance_ok_o, low_side_drive_two},
					3'b000);
			end else if (k == 1) begin
				output_undervolt_protect <= 1'b1;
				repeat (5) @(posedge aclk);
				output_undervolt_protect <= 1'b0;
				go_parked();
				rdreg(8'h08);
				chk({rd[12], rd[10:8]}, {1'b1, VRS_FAULT_PARK});
				enable_bar_input <= 1'b0;
				repeat (10) @(posedge aclk);
				rdreg(8'h08);
				chk(rd[12], 1'b0);
			end else if (k == 2) begin
				overtemp_trip <= 1'b1;
				overtemp_cooled <= 1'b0;
				repeat (5) @(posedge aclk);
				overtemp_trip <= 1'b0;
				go_parked();
				enable_bar_input <= 1'b0;
				repeat (10) @(posedge aclk);
				rdreg(8'h08);
				chk(rd[12], 1'b1);
				test_level_detect <= 1'b1;
				repeat (10) @(posedge aclk);
				rdreg(8'h08);
				chk(rd[12], 1'b0);
				{test_level_detect, overtemp_cooled} <= 2'b01;
			end else begin
				// fault and lockout together in run: latch set, state forced off
				output_undervolt_protect <= 1'b1;
				supply_undervolt_lockout <= 1'b1;
				repeat (5) @(posedge aclk);
				chk({switcher_hiz, output_in_regulation_flag_oe, phase_balance_ok_oe},
					3'b100);
				rdreg(8'h08);
				chk({rd[12], rd[10:8]}, 4'h8);
				supply_below_half <= 1'b1;
				repeat (5) @(posedge aclk);
				rdreg(8'h08);
				chk(rd[12], 1'b0);
				supply_por_ok <= 1'b0;
				repeat (5) @(posedge aclk);
				rdreg(8'h08);
				chk(rd[10:8], 3'h0);
			end
		end
		conclude();
	end
endmodule : vrs_sequencer_test
